// ==== config_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "emi_glue_consts.svh"

module config_decoder
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        scan_active_i,
	input  wire logic [31:0] scan_addr_i,
	output logic             config_bit_input_o
);

	// Configuration pattern, one bit per scanned word address
	localparam logic [63:0] CFG_ROM = `CFG_TABLE;

	logic cfg_out;
	logic next_cfg_out;
	logic hit;

	always_comb
	begin
		hit = CFG_ROM[scan_addr_i[`CFG_INDEX_LSB +: `CFG_INDEX_W]];
		if (scan_addr_i[`CFG_TOP_BIT])
			next_cfg_out = ~hit;
		else if (scan_active_i)
			next_cfg_out = 1'b0;
		else
			next_cfg_out = 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cfg_out <= 1'b1;
		else
			cfg_out <= next_cfg_out;
	end

	assign config_bit_input_o = cfg_out;

	a_cfg_read_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		scan_addr_i[`CFG_TOP_BIT] && CFG_ROM[scan_addr_i[`CFG_INDEX_LSB +: `CFG_INDEX_W]]
		|=> !config_bit_input_o)
		else $error("decoder did not answer 0 for a set bit");

	a_cfg_read_miss: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		scan_addr_i[`CFG_TOP_BIT] && !CFG_ROM[scan_addr_i[`CFG_INDEX_LSB +: `CFG_INDEX_W]]
		|=> config_bit_input_o)
		else $error("decoder did not answer 1 for a clear bit");

	a_cfg_scan_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		scan_active_i && !scan_addr_i[`CFG_TOP_BIT] |=> !config_bit_input_o)
		else $error("config input not held low during scan");

	a_cfg_idle_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!scan_active_i && !scan_addr_i[`CFG_TOP_BIT] |=> config_bit_input_o)
		else $error("decoder answered outside the read cycle");

endmodule // config_decoder

`default_nettype wire

// ==== cpu_mem_port_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpu_mem_port_model
#(
	parameter int STROBE_CLKS = 3
)
(
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic        rd_i,
	input  wire logic        video_i,
	input  wire logic [31:0] addr_i,
	input  wire logic        wait_i,
	output logic             strobe_n_o,
	output logic             video_select_o,
	output logic             read_not_write_o,
	output logic [31:0]      mem_addr_o,
	output logic             busy_o
);
	int cnt = 0;

	initial
	begin
		strobe_n_o       = 1'b1;
		video_select_o   = 1'b0;
		read_not_write_o = 1'b0;
		mem_addr_o       = 32'h0000_0000;
		busy_o           = 1'b0;
	end

	always @(posedge clk_i)
	begin
		if (!busy_o && go_i)
		begin
			busy_o           <= 1'b1;
			strobe_n_o       <= 1'b0;
			video_select_o   <= video_i;
			read_not_write_o <= rd_i;
			mem_addr_o       <= addr_i;
			cnt              <= 1;
		end
		else if (busy_o && cnt < STROBE_CLKS)
			cnt <= cnt + 1;
		else if (busy_o && !strobe_n_o)
			strobe_n_o <= 1'b1;
		else if (busy_o && wait_i !== 1'b1)
		begin
			// Extra data-setup phases last while wait is held
			busy_o           <= 1'b0;
			video_select_o   <= 1'b0;
			read_not_write_o <= ~read_not_write_o;
			mem_addr_o       <= ~mem_addr_o;
		end
	end
endmodule // cpu_mem_port_model

`default_nettype wire

// ==== emi_glue_consts.svh ====
`ifndef EMI_GLUE_CONSTS_SVH
`define EMI_GLUE_CONSTS_SVH

// Clock periods in ns
`define CLK_NS              20
`define CPU_CLK_NS          50
`define HALF_CYCLE_NS       25
`define SERIAL_CLK_NS       50

// Cycle lengths of the memory port and the video micro-port
`define BASIC_CPU_CLKS      4
`define UPORT_WR_SCLKS      5
`define UPORT_RD_SCLKS      7
`define VIDEO_WR_CPU_CLKS   6
`define VIDEO_RD_CPU_CLKS   7

// Wait strobe delay line
`define WAIT_LINE_LEN       16
`define TAP_W               4
`define WR_DELAY_RESET      ((`VIDEO_WR_CPU_CLKS - `BASIC_CPU_CLKS) * `CPU_CLK_NS / `CLK_NS)
`define RD_EXTRA_RESET      (((`VIDEO_RD_CPU_CLKS - `VIDEO_WR_CPU_CLKS) * `CPU_CLK_NS + `CLK_NS - 1) / `CLK_NS)

// Memory organisation: two banks of eight 256K x 4 devices, 32-bit words
`define BANK_ADDR_BIT       20

// Configuration decoder
`define CFG_TOP_BIT         31
`define CFG_INDEX_LSB       2
`define CFG_INDEX_W         6
`define CFG_TABLE           64'h0000_00F3_5A0C_91E6

`endif

// ==== emi_glue_pkg.sv ====
package emi_glue_pkg;

	typedef enum logic [1:0]
	{
		ACC_IDLE,
		ACC_WRITE,
		ACC_READ
	} access_t;

endpackage

// ==== emi_wait_and_config_glue.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "emi_glue_consts.svh"

module emi_wait_and_config_glue
(
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic               wait_insert_strobe_n_i,
	input  wire logic               video_select_i,
	input  wire logic               read_not_write_i,
	input  wire logic [31:0]        mem_addr_i,
	input  wire logic               timing_load_i,
	input  wire logic [`TAP_W-1:0]  write_delay_i,
	input  wire logic [`TAP_W-1:0]  read_extra_i,
	input  wire logic [7:0]         serial_period_ns_i,
	input  wire logic               cpu_in_reset_i,
	input  wire logic [31:0]        muxed_addr_data_pins_i,
	output logic                    wait_request_in_o,
	output logic [1:0]              bank_select_o,
	output logic                    wait_timing_short_o,
	output logic                    config_bit_input_o
);

	logic                     rst_meta;
	logic                     rst_n;

	emi_glue_pkg::access_t    access;
	emi_glue_pkg::access_t    next_access;
	logic [`WAIT_LINE_LEN-1:0] delay_line;
	logic [`WAIT_LINE_LEN-1:0] next_delay_line;
	logic [`TAP_W-1:0]        wr_delay;
	logic [`TAP_W-1:0]        next_wr_delay;
	logic [`TAP_W-1:0]        rd_extra;
	logic [`TAP_W-1:0]        next_rd_extra;
	logic [`TAP_W-1:0]        tap;
	logic                     strobe_act;
	logic                     wait_q;
	logic                     next_wait;
	logic [1:0]               bank_q;
	logic [1:0]               next_bank;
	logic                     short_q;
	logic                     next_short;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Nanoseconds that a micro-port access of n serial clocks needs
	function automatic logic [15:0] uport_need_ns(input logic [3:0] sclks,
		input logic [7:0] period);
		uport_need_ns = 16'(sclks) * 16'(period);
	endfunction

	// True while the strobe sits in any stage up to the tap; a single tap
	// would leave a gap whenever the strobe is shorter than the delay
	function automatic logic window_hit(input logic [`WAIT_LINE_LEN-1:0] line,
		input logic [`TAP_W-1:0] last);
		window_hit = 1'b0;
		for (int i = 0; i < `WAIT_LINE_LEN; i++)
			if (i <= int'(last) && line[i])
				window_hit = 1'b1;
	endfunction

	// Nanoseconds the extended processor cycle provides for a given delay tap
	function automatic logic [15:0] cycle_give_ns(input logic [`TAP_W:0] taps);
		cycle_give_ns = 16'(`BASIC_CPU_CLKS * `CPU_CLK_NS) + 16'(taps) * 16'(`CLK_NS);
	endfunction

	assign strobe_act = !wait_insert_strobe_n_i;

	// Wait timing registers, reloaded while timing_load_i is high
	always_comb
	begin
		next_wr_delay = wr_delay;
		next_rd_extra = rd_extra;
		if (timing_load_i)
		begin
			next_wr_delay = write_delay_i;
			next_rd_extra = read_extra_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_delay <= `TAP_W'(`WR_DELAY_RESET);
			rd_extra <= `TAP_W'(`RD_EXTRA_RESET);
		end
		else
		begin
			wr_delay <= next_wr_delay;
			rd_extra <= next_rd_extra;
		end
	end

	// Direction of the current video access and the wait strobe delay line
	always_comb
	begin
		next_delay_line = {delay_line[`WAIT_LINE_LEN-2:0], strobe_act};
		next_access     = access;
		case (access)
			emi_glue_pkg::ACC_IDLE:
				if (strobe_act && video_select_i)
					next_access = read_not_write_i ? emi_glue_pkg::ACC_READ
						: emi_glue_pkg::ACC_WRITE;
			emi_glue_pkg::ACC_WRITE,
			emi_glue_pkg::ACC_READ:
				if (!strobe_act && !wait_q)
					next_access = emi_glue_pkg::ACC_IDLE;
			default:
				next_access = emi_glue_pkg::ACC_IDLE;
		endcase
	end

	// Reads tap one extra wait state further down the line; direction is
	// latched at strobe start so a late change cannot shorten the cycle
	always_comb
	begin
		if (access == emi_glue_pkg::ACC_READ
			|| (access == emi_glue_pkg::ACC_IDLE && read_not_write_i))
			tap = `TAP_W'(wr_delay + rd_extra);
		else
			tap = wr_delay;
	end

	// Wait raised the clock after strobe start, held until the delayed copy has passed the tap
	always_comb
	begin
		next_wait = video_select_i && (strobe_act || window_hit(delay_line, tap));
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			access     <= emi_glue_pkg::ACC_IDLE;
			delay_line <= '0;
			wait_q     <= 1'b0;
		end
		else
		begin
			access     <= next_access;
			delay_line <= next_delay_line;
			wait_q     <= next_wait;
		end
	end

	// Combinational so a deselect drops wait in the same cycle
	assign wait_request_in_o = wait_q && video_select_i;

	// Bank select and wait sufficiency check
	always_comb
	begin
		next_bank = mem_addr_i[`BANK_ADDR_BIT] ? 2'h2 : 2'h1;
		next_short = (uport_need_ns(4'(`UPORT_WR_SCLKS), serial_period_ns_i)
			> cycle_give_ns({1'b0, wr_delay}))
			|| (uport_need_ns(4'(`UPORT_RD_SCLKS), serial_period_ns_i)
			> cycle_give_ns({1'b0, wr_delay} + {1'b0, rd_extra}));
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bank_q  <= 2'h1;
			short_q <= 1'b0;
		end
		else
		begin
			bank_q  <= next_bank;
			short_q <= next_short;
		end
	end

	assign bank_select_o       = bank_q;
	assign wait_timing_short_o = short_q;

	// Later selects after configuration are harmless, so no lockout here
	config_decoder u_config_decoder
	(
		.clk_i              (clk_i),
		.rst_n_i            (rst_n),
		.scan_active_i      (cpu_in_reset_i),
		.scan_addr_i        (muxed_addr_data_pins_i),
		.config_bit_input_o (config_bit_input_o)
	);

	a_no_wait_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
		!video_select_i |-> !wait_request_in_o)
		else $error("wait raised for a non-video access");

	a_wait_follows_strobe: assert property (@(posedge clk_i) disable iff (!rst_n)
		video_select_i && strobe_act ##1 video_select_i |-> wait_request_in_o)
		else $error("video access strobe not routed to wait");

	a_read_tap_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
		video_select_i && read_not_write_i && delay_line[`TAP_W'(wr_delay + rd_extra)]
		##1 video_select_i |-> wait_request_in_o)
		else $error("read wait not extended by delayed strobe");

	a_wait_release: assert property (@(posedge clk_i) disable iff (!rst_n)
		!strobe_act && !window_hit(delay_line, tap) |=> !wait_request_in_o)
		else $error("wait held after strobe and delay ended");

	a_write_stretch: assert property (@(posedge clk_i) disable iff (!rst_n)
		video_select_i && !read_not_write_i && $fell(strobe_act) && wr_delay == 4'h5
		&& !timing_load_i
		|-> (video_select_i && !read_not_write_i) [*5] |=> wait_request_in_o)
		else $error("write wait shorter than programmed delay");

	a_short_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
		uport_need_ns(4'(`UPORT_WR_SCLKS), serial_period_ns_i) > cycle_give_ns({1'b0, wr_delay})
		|=> wait_timing_short_o)
		else $error("insufficient wait timing not flagged");

	a_bank_onehot: assert property (@(posedge clk_i) disable iff (!rst_n)
		##1 $onehot(bank_select_o) && (bank_select_o[1] == $past(mem_addr_i[`BANK_ADDR_BIT])))
		else $error("bank select not one-hot from address");

	a_timing_load: assert property (@(posedge clk_i) disable iff (!rst_n)
		timing_load_i |=> wr_delay == $past(write_delay_i) && rd_extra == $past(read_extra_i))
		else $error("wait timing not reprogrammed on load");

endmodule // emi_wait_and_config_glue

`default_nettype wire

// ==== tb_emi_wait_and_config_glue.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "emi_glue_consts.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module tb_emi_wait_and_config_glue;
	localparam logic [63:0] cfg_table = `CFG_TABLE;
	logic              clk_i     = 1'b0;
	logic              reset_n_i = 1'b0;
	logic              go = 1'b0, rd = 1'b0, vid = 1'b0, load = 1'b0, in_reset = 1'b0;
	logic [31:0]       addr = 32'h0000_0000, pins = 32'h0000_0000;
	logic [`TAP_W-1:0] wr_delay = 4'h5, rd_extra = 4'h3;
	logic [7:0]        period = 8'h32;
	logic              strobe_n, video_select, rnw, busy, wait_req, short_flag, cfg_bit;
	logic [31:0]       mem_addr;
	logic [1:0]        bank;
	int                err_count = 0, cmp_count = 0, wr_n = 0;

	cpu_mem_port_model cpu (.clk_i(clk_i), .go_i(go), .rd_i(rd), .video_i(vid),
		.addr_i(addr), .wait_i(wait_req), .strobe_n_o(strobe_n),
		.video_select_o(video_select), .read_not_write_o(rnw),
		.mem_addr_o(mem_addr), .busy_o(busy));

	emi_wait_and_config_glue DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.wait_insert_strobe_n_i(strobe_n), .video_select_i(video_select),
		.read_not_write_i(rnw), .mem_addr_i(mem_addr), .timing_load_i(load),
		.write_delay_i(wr_delay), .read_extra_i(rd_extra), .serial_period_ns_i(period),
		.cpu_in_reset_i(in_reset), .muxed_addr_data_pins_i(pins),
		.wait_request_in_o(wait_req), .bank_select_o(bank),
		.wait_timing_short_o(short_flag), .config_bit_input_o(cfg_bit));

	initial
	begin
		forever #10 clk_i = ~clk_i;
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic run_cycle(input logic r, input logic v, input logic [31:0] a,
		output int waits);
		bit ended;
		waits = 0;
		ended = 1'b0;
		@(posedge clk_i);
		go   <= 1'b1;
		rd   <= r;
		vid  <= v;
		addr <= a;
		@(posedge clk_i);
		go <= 1'b0;
		for (int n = 0; n < 100 && !ended; n++)
		begin
			@(negedge clk_i);
			if (wait_req === 1'b1)
				waits++;
			if (n == 1)
				`CHK("bank select", a[20] ? 2'h2 : 2'h1, bank)
			ended = (busy === 1'b0);
		end
		if (!ended)
		begin
			err_count++;
			$display("unexpected cycle end: expected 0 seen 1");
			test_done();
		end
	endtask

	task automatic load_timing(input logic [3:0] w, input logic [3:0] x);
		@(posedge clk_i);
		load     <= 1'b1;
		wr_delay <= w;
		rd_extra <= x;
		@(posedge clk_i);
		load <= 1'b0;
	endtask

	task automatic check_short(input logic [7:0] p, input logic e);
		@(posedge clk_i);
		period <= p;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		`CHK("short flag", e, short_flag)
	endtask

	task automatic pin_check(input logic [31:0] p, input logic r, input logic e);
		@(posedge clk_i);
		pins     <= p;
		in_reset <= r;
		@(posedge clk_i);
		@(negedge clk_i);
		`CHK("config bit", e, cfg_bit)
	endtask

	task automatic check_reset();
		@(negedge clk_i);
		`CHK("wait in reset", 1'b0, wait_req)
		`CHK("bank in reset", 2'h1, bank)
		`CHK("config in reset", 1'b1, cfg_bit)
	endtask

	task automatic video_write_read();
		int rd_n;
		run_cycle(1'b0, 1'b1, 32'h0010_0000, wr_n);
		// Five clk cycles make up the two extra processor clocks of a write
		`CHK("write waits", 1'b1, wr_n >= 8 && wr_n <= 10)
		run_cycle(1'b1, 1'b1, 32'h0000_0040, rd_n);
		`CHK("read extra waits", 3, rd_n - wr_n)
	endtask

	task automatic off_video();
		int w_n, r_n;
		run_cycle(1'b0, 1'b0, 32'h0010_0000, w_n);
		run_cycle(1'b1, 1'b0, 32'h0000_0000, r_n);
		`CHK("waits off video", 0, w_n + r_n)
	endtask

	task automatic reload_timing();
		int f_n;
		load_timing(4'h2, 4'h1);
		run_cycle(1'b0, 1'b1, 32'h0000_0000, f_n);
		`CHK("reloaded write waits", 3, wr_n - f_n)
		check_short(8'h32, 1'b1);
		load_timing(4'h5, 4'h3);
		check_short(8'h32, 1'b0);
		check_short(8'h34, 1'b1);
	endtask

	task automatic config_scan();
		logic [31:0] p;
		p = 32'h7FFF_FFFF;
		for (int k = 30; k >= 0; k--)
		begin
			pin_check(p, 1'b1, 1'b0);
			p[k] = 1'b0;
		end
		pin_check(p, 1'b1, 1'b0);
	endtask

	task automatic config_decode();
		for (int i = 0; i < 64; i++)
			pin_check({1'b1, 23'h0, i[5:0], 2'h0}, 1'b1, ~cfg_table[i]);
		pin_check(32'h7FFF_FFF0, 1'b1, 1'b0);
		pin_check(32'h0000_0004, 1'b0, 1'b1);
	endtask

	initial
	begin
		repeat (3) @(posedge clk_i);
		check_reset();
		@(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		video_write_read();
		off_video();
		reload_timing();
		config_scan();
		config_decode();
		test_done();
	end
endmodule // tb_emi_wait_and_config_glue

`default_nettype wire
